// ---- common/rnla_regs.svh ----
`ifndef RNLA_REGS_SVH
`define RNLA_REGS_SVH

// register byte offsets
`define RNLA_REG_RETRY 4'h0
`define RNLA_REG_CONTACT 4'h4
`define RNLA_REG_STATUS 4'h8

// reset values and sequence constants
`define RNLA_RETRY_RST 24'h000400
`define RNLA_CONTACT_RST 24'h100000
`define RNLA_SEQ_INIT 7'h7F
`define RNLA_MAX_TRIES 3'h6

// identifier digit codes
`define RNLA_ID_LOCO 4'h1
`define RNLA_ID_WAY_A 4'h3
`define RNLA_ID_VEH_A 4'h4
`define RNLA_ID_WAY_B 4'h5
`define RNLA_ID_VEH_B 4'h6

`endif

// ---- common/rnla_pkg.sv ----
`include "rnla_regs.svh"

package rnla_pkg;

  typedef logic [6:0] rnla_seq_t;

  typedef struct packed {
    logic [2:0] grp;
    rnla_seq_t ns;
    rnla_seq_t nr;
    logic dconf;
    logic [59:0] addr;
    logic [15:0] tag;
  } rnla_pkt_s;

  typedef struct packed {
    logic [2:0] grp;
    rnla_seq_t ns;
    logic direct;
    logic [59:0] addr;
    logic [15:0] tag;
  } rnla_rx_s;

  typedef enum logic [1:0] {
    RNLA_IDLE = 2'b00,
    RNLA_FLUSH = 2'b01
  } rnla_state_e;

  // digit 1 is the identifier; trailing digits masked per device class
  function automatic logic [59:0] rnla_user_key(input logic [59:0] a);
    logic [59:0] k;
    k = a;
    if (a[59:56] == `RNLA_ID_WAY_A || a[59:56] == `RNLA_ID_WAY_B) begin
      k[11:0] = 12'h000;
    end else if (a[59:56] == `RNLA_ID_LOCO || a[59:56] == `RNLA_ID_VEH_A ||
                 a[59:56] == `RNLA_ID_VEH_B) begin
      k[7:0] = 8'h00;
    end
    return k;
  endfunction

endpackage

// ---- core/rnla_dup_filter.sv ----
`timescale 1ns/1ps
`include "rnla_regs.svh"

module rnla_dup_filter
  import rnla_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic rx_valid,
  input wire rnla_rx_s rx_pkt,
  output logic fwd_valid,
  output rnla_rx_s fwd_pkt,
  output logic [59:0] fwd_user,
  output logic dup_drop
);

  rnla_seq_t list_r [4][3];
  rnla_seq_t list_nxt [4][3];
  logic fwd_valid_nxt;
  rnla_rx_s fwd_pkt_nxt;
  logic [59:0] fwd_user_nxt;
  logic dup_drop_nxt;
  logic odd_chk;
  logic hit;
  logic [1:0] li;

  always_comb begin
    list_nxt = list_r;
    li = rx_pkt.grp[2:1];
    odd_chk = rx_valid && rx_pkt.grp[0] && !rx_pkt.direct;
    hit = (rx_pkt.ns == list_r[li][0]) || (rx_pkt.ns == list_r[li][1]) ||
          (rx_pkt.ns == list_r[li][2]);
    fwd_valid_nxt = rx_valid && !(odd_chk && hit);
    dup_drop_nxt = odd_chk && hit;
    fwd_pkt_nxt = rx_valid ? rx_pkt : fwd_pkt;
    fwd_user_nxt = rx_valid ? rnla_user_key(rx_pkt.addr) : fwd_user;
    if (odd_chk && !hit) begin
      list_nxt[li][2] = list_r[li][1];
      list_nxt[li][1] = list_r[li][0];
      list_nxt[li][0] = rx_pkt.ns;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int g = 0; g < 4; g++) begin
        for (int j = 0; j < 3; j++) begin
          list_r[g][j] <= `RNLA_SEQ_INIT;
        end
      end
      fwd_valid <= 1'b0;
      fwd_pkt <= '0;
      fwd_user <= '0;
      dup_drop <= 1'b0;
    end else begin
      list_r <= list_nxt;
      fwd_valid <= fwd_valid_nxt;
      fwd_pkt <= fwd_pkt_nxt;
      fwd_user <= fwd_user_nxt;
      dup_drop <= dup_drop_nxt;
    end
  end

  a_dup_discard: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rx_valid && rx_pkt.grp[0] && !rx_pkt.direct &&
     rx_pkt.ns == list_r[rx_pkt.grp[2:1]][0]) |=> (!fwd_valid && dup_drop))
    else $error("duplicate odd packet was forwarded");

  a_direct_pass: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rx_valid && rx_pkt.direct) |=> (fwd_valid && fwd_pkt.direct))
    else $error("direct user traffic was not forwarded");

endmodule // rnla_dup_filter

// ---- core/rnla_engine.sv ----
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "rnla_regs.svh"

module rnla_engine
  import rnla_pkg::*;
#(
  parameter int HOLD_DEPTH = 4,
  parameter int TMR_W = 24
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tx_valid,
  input wire rnla_pkt_s tx_pkt,
  output logic tx_ready,
  output logic out_valid,
  output rnla_pkt_s out_pkt,
  output logic [59:0] out_user,
  input wire logic out_ready,
  input wire logic rx_valid,
  input wire rnla_rx_s rx_pkt,
  output logic fwd_valid,
  output rnla_rx_s fwd_pkt,
  output logic [59:0] fwd_user,
  output logic dup_drop,
  input wire logic ack_valid,
  input wire logic [2:0] ack_grp,
  input wire logic nr_valid,
  input wire logic [2:0] nr_grp,
  input wire rnla_seq_t nr_value,
  output logic svc_valid,
  output logic [15:0] svc_tag,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  localparam int PW = (HOLD_DEPTH > 1) ? $clog2(HOLD_DEPTH) : 1;
  localparam int CW = $clog2(HOLD_DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(HOLD_DEPTH);

  function automatic logic [2:0] low_slot(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  rnla_state_e state_r, state_nxt;
  logic [7:0] slot_v_r, slot_v_nxt;
  rnla_pkt_s slot_r [8];
  rnla_pkt_s slot_nxt [8];
  logic [3:0] outst_r, outst_nxt;
  rnla_pkt_s held_r [4];
  rnla_pkt_s held_nxt [4];
  rnla_seq_t ons_r [4];
  rnla_seq_t ons_nxt [4];
  rnla_seq_t orig_r [4];
  rnla_seq_t orig_nxt [4];
  rnla_seq_t nsn_r [4];
  rnla_seq_t nsn_nxt [4];
  rnla_seq_t nr_r [4];
  rnla_seq_t nr_nxt [4];
  rnla_seq_t lack_r [4];
  rnla_seq_t lack_nxt [4];
  logic [2:0] try_r [4];
  logic [2:0] try_nxt [4];
  logic [TMR_W-1:0] tmr_r [4];
  logic [TMR_W-1:0] tmr_nxt [4];
  logic [TMR_W-1:0] ctmr_r, ctmr_nxt;
  logic [TMR_W-1:0] retry_lim_r, retry_lim_nxt;
  logic [TMR_W-1:0] contact_lim_r, contact_lim_nxt;
  logic [CW-1:0] cnt_r [4];
  logic [CW-1:0] cnt_nxt [4];
  logic [PW-1:0] rp_r [4];
  logic [PW-1:0] rp_nxt [4];
  logic [PW-1:0] wp_r [4];
  logic [PW-1:0] wp_nxt [4];
  rnla_pkt_s fifo_mem [4][HOLD_DEPTH];
  logic fifo_we;
  logic [1:0] fifo_wi;
  rnla_pkt_s fifo_wd;
  logic tx_ready_nxt, out_valid_nxt, svc_valid_nxt;
  rnla_pkt_s out_pkt_nxt;
  logic [59:0] out_user_nxt;
  logic [15:0] svc_tag_nxt;
  logic [31:0] reg_rdata_nxt;
  logic out_take, acc, drop_v, busy_done, stamp_any, expire;
  logic [2:0] sel;
  logic [3:0] stamp_e;
  logic [3:0] retry_e;
  logic [3:0] nz;
  rnla_pkt_s p, drop_p;

  always_comb begin
    state_nxt = state_r;
    slot_v_nxt = slot_v_r;
    slot_nxt = slot_r;
    outst_nxt = outst_r;
    held_nxt = held_r;
    ons_nxt = ons_r;
    orig_nxt = orig_r;
    nsn_nxt = nsn_r;
    nr_nxt = nr_r;
    lack_nxt = lack_r;
    try_nxt = try_r;
    tmr_nxt = tmr_r;
    cnt_nxt = cnt_r;
    rp_nxt = rp_r;
    wp_nxt = wp_r;
    retry_lim_nxt = retry_lim_r;
    contact_lim_nxt = contact_lim_r;
    fifo_we = 1'b0;
    fifo_wi = tx_pkt.grp[2:1];
    fifo_wd = tx_pkt;
    out_valid_nxt = out_valid;
    out_pkt_nxt = out_pkt;
    out_user_nxt = out_user;
    drop_v = 1'b0;
    drop_p = '0;
    busy_done = 1'b0;
    stamp_any = 1'b0;
    stamp_e = '0;
    retry_e = '0;
    p = '0;
    nz = '0;
    reg_rdata_nxt = 32'h0000_0000;
    // register port
    if (reg_wr && reg_addr == `RNLA_REG_RETRY) begin
      retry_lim_nxt = reg_wdata[TMR_W-1:0];
    end
    if (reg_wr && reg_addr == `RNLA_REG_CONTACT) begin
      contact_lim_nxt = reg_wdata[TMR_W-1:0];
    end
    for (int e = 0; e < 4; e++) begin
      nz[e] = (cnt_r[e] != '0);
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `RNLA_REG_RETRY: reg_rdata_nxt = 32'(retry_lim_r);
        `RNLA_REG_CONTACT: reg_rdata_nxt = 32'(contact_lim_r);
        `RNLA_REG_STATUS: reg_rdata_nxt = {22'h0, state_r, nz, outst_r};
        default: reg_rdata_nxt = 32'h0000_0000;
      endcase
    end
    // output queue: lowest numbered pending group first
    sel = low_slot(slot_v_r);
    out_take = (!out_valid || out_ready);
    if (out_take) begin
      out_valid_nxt = |slot_v_r;
      if (|slot_v_r) begin
        out_pkt_nxt = slot_r[sel];
        out_user_nxt = rnla_user_key(slot_r[sel].addr);
        slot_v_nxt[sel] = 1'b0;
      end
    end
    acc = tx_valid && tx_ready;
    // odd group: stamp and send at once
    if (acc && tx_pkt.grp[0]) begin
      p = tx_pkt;
      p.ns = ons_r[tx_pkt.grp[2:1]];
      ons_nxt[tx_pkt.grp[2:1]] = ons_r[tx_pkt.grp[2:1]] + 7'h01;
      slot_nxt[{tx_pkt.grp[2:1], 1'b1}] = p;
      slot_v_nxt[{tx_pkt.grp[2:1], 1'b1}] = 1'b1;
    end
    // acknowledgment and receive number from the receive path
    if (ack_valid && !ack_grp[0]) begin
      outst_nxt[ack_grp[2:1]] = 1'b0;
      try_nxt[ack_grp[2:1]] = 3'h0;
    end
    if (nr_valid && !nr_grp[0]) begin
      nr_nxt[nr_grp[2:1]] = nr_value;
    end
    for (int e = 0; e < 4; e++) begin
      if (outst_r[e] && tmr_r[e] != '1) begin
        tmr_nxt[e] = tmr_r[e] + TMR_W'(1);
      end
      // hold behind an outstanding or waiting packet
      if (acc && !tx_pkt.grp[0] && tx_pkt.grp[2:1] == 2'(e)) begin
        if (outst_r[e] || nz[e] || slot_v_r[2*e]) begin
          fifo_we = 1'b1;
          wp_nxt[e] = (wp_r[e] == PW'(HOLD_DEPTH - 1)) ? '0 : wp_r[e] + PW'(1);
          cnt_nxt[e] = cnt_r[e] + CW'(1);
          p = tx_pkt;
        end else begin
          stamp_e[e] = 1'b1;
          p = tx_pkt;
        end
      end else if (state_r == RNLA_IDLE && !outst_r[e] && nz[e] &&
                   !slot_v_r[2*e]) begin
        stamp_e[e] = 1'b1;
        p = fifo_mem[e][rp_r[e]];
        rp_nxt[e] = (rp_r[e] == PW'(HOLD_DEPTH - 1)) ? '0 : rp_r[e] + PW'(1);
        cnt_nxt[e] = cnt_nxt[e] - CW'(1);
      end
      if (stamp_e[e]) begin
        orig_nxt[e] = p.ns;
        p.ns = nsn_r[e];
        p.nr = nr_r[e];
        lack_nxt[e] = nr_r[e];
        nsn_nxt[e] = nsn_r[e] + 7'h01;
        try_nxt[e] = 3'h1;
        tmr_nxt[e] = '0;
        outst_nxt[e] = 1'b1;
        held_nxt[e] = p;
        slot_nxt[2*e] = p;
        slot_v_nxt[2*e] = 1'b1;
      end
      // retry: one group per cycle, lowest first
      if (state_r == RNLA_IDLE && !stamp_any && outst_r[e] &&
          tmr_r[e] > retry_lim_r && !slot_v_r[2*e] &&
          !(ack_valid && ack_grp == 3'(2*e))) begin
        stamp_any = 1'b1;
        retry_e[e] = 1'b1;
        p = held_r[e];
        p.nr = nr_r[e];
        held_nxt[e] = p;
        if (try_r[e] > `RNLA_MAX_TRIES) begin
          outst_nxt[e] = 1'b0;
          drop_v = 1'b1;
          drop_p = p;
        end else begin
          tmr_nxt[e] = '0;
          try_nxt[e] = try_r[e] + 3'h1;
          slot_nxt[2*e] = p;
          slot_v_nxt[2*e] = 1'b1;
        end
      end
    end
    // contact supervision
    if (rx_valid || ack_valid) begin
      ctmr_nxt = '0;
    end else begin
      ctmr_nxt = (ctmr_r == '1) ? ctmr_r : ctmr_r + TMR_W'(1);
    end
    expire = (ctmr_r >= contact_lim_r) && ((|outst_r) || (|nz));
    unique case (state_r)
      RNLA_IDLE: begin
        if (expire) begin
          state_nxt = RNLA_FLUSH;
        end
      end
      RNLA_FLUSH: begin
        for (int e = 0; e < 4; e++) begin
          if (!busy_done && outst_r[e]) begin
            busy_done = 1'b1;
            outst_nxt[e] = 1'b0;
            slot_v_nxt[2*e] = 1'b0;
            drop_v = 1'b1;
            drop_p = held_r[e];
          end
        end
        for (int e = 0; e < 4; e++) begin
          if (!busy_done && nz[e]) begin
            busy_done = 1'b1;
            drop_v = 1'b1;
            drop_p = fifo_mem[e][rp_r[e]];
            rp_nxt[e] = (rp_r[e] == PW'(HOLD_DEPTH - 1)) ? '0 : rp_r[e] + PW'(1);
            cnt_nxt[e] = cnt_nxt[e] - CW'(1);
          end
        end
        if (!busy_done) begin
          state_nxt = RNLA_IDLE;
          ctmr_nxt = '0;
        end
      end
    endcase
    svc_valid_nxt = drop_v && drop_p.dconf;
    svc_tag_nxt = drop_v ? drop_p.tag : svc_tag;
    tx_ready_nxt = (state_nxt == RNLA_IDLE) && !(|{slot_v_nxt[7], slot_v_nxt[5],
                   slot_v_nxt[3], slot_v_nxt[1]});
    for (int e = 0; e < 4; e++) begin
      if (cnt_nxt[e] == FULL) begin
        tx_ready_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (fifo_we) begin
      fifo_mem[fifo_wi][wp_r[fifo_wi]] <= fifo_wd;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= RNLA_IDLE;
      slot_v_r <= '0;
      outst_r <= '0;
      ctmr_r <= '0;
      retry_lim_r <= TMR_W'(`RNLA_RETRY_RST);
      contact_lim_r <= TMR_W'(`RNLA_CONTACT_RST);
      for (int i = 0; i < 8; i++) begin
        slot_r[i] <= '0;
      end
      for (int e = 0; e < 4; e++) begin
        held_r[e] <= '0;
        ons_r[e] <= '0;
        orig_r[e] <= '0;
        nsn_r[e] <= '0;
        nr_r[e] <= '0;
        lack_r[e] <= '0;
        try_r[e] <= '0;
        tmr_r[e] <= '0;
        cnt_r[e] <= '0;
        rp_r[e] <= '0;
        wp_r[e] <= '0;
      end
      tx_ready <= 1'b0;
      out_valid <= 1'b0;
      out_pkt <= '0;
      out_user <= '0;
      svc_valid <= 1'b0;
      svc_tag <= '0;
      reg_rdata <= '0;
    end else begin
      state_r <= state_nxt;
      slot_v_r <= slot_v_nxt;
      slot_r <= slot_nxt;
      outst_r <= outst_nxt;
      held_r <= held_nxt;
      ons_r <= ons_nxt;
      orig_r <= orig_nxt;
      nsn_r <= nsn_nxt;
      nr_r <= nr_nxt;
      lack_r <= lack_nxt;
      try_r <= try_nxt;
      tmr_r <= tmr_nxt;
      ctmr_r <= ctmr_nxt;
      retry_lim_r <= retry_lim_nxt;
      contact_lim_r <= contact_lim_nxt;
      cnt_r <= cnt_nxt;
      rp_r <= rp_nxt;
      wp_r <= wp_nxt;
      tx_ready <= tx_ready_nxt;
      out_valid <= out_valid_nxt;
      out_pkt <= out_pkt_nxt;
      out_user <= out_user_nxt;
      svc_valid <= svc_valid_nxt;
      svc_tag <= svc_tag_nxt;
      reg_rdata <= reg_rdata_nxt;
    end
  end

  rnla_dup_filter u_dup (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .rx_valid(rx_valid),
    .rx_pkt(rx_pkt),
    .fwd_valid(fwd_valid),
    .fwd_pkt(fwd_pkt),
    .fwd_user(fwd_user),
    .dup_drop(dup_drop)
  );

  a_out_prio: assert property (@(posedge core_clk) disable iff (!arst_n)
    (out_take && |slot_v_r) |=> (out_pkt.grp == $past(sel) && out_valid))
    else $error("output did not take the lowest pending group");

  a_odd_stamp: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc && tx_pkt.grp[0]) |=>
    (ons_r[$past(tx_pkt.grp[2:1])] == $past(ons_r[tx_pkt.grp[2:1]]) + 7'h01))
    else $error("odd send number did not advance");

  a_one_outst: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc && !tx_pkt.grp[0] && outst_r[tx_pkt.grp[2:1]]) |=>
    (nsn_r[$past(tx_pkt.grp[2:1])] == $past(nsn_r[tx_pkt.grp[2:1]])))
    else $error("second packet stamped while one outstanding");

  a_stamp_seq: assert property (@(posedge core_clk) disable iff (!arst_n)
    stamp_e[1] |=> (try_r[1] == 3'h1 && tmr_r[1] == '0 && outst_r[1] &&
                    nsn_r[1] == $past(nsn_r[1]) + 7'h01))
    else $error("stamping did not set try, timer and next send");

  a_stamp_nr: assert property (@(posedge core_clk) disable iff (!arst_n)
    stamp_e[1] |=> (lack_r[1] == $past(nr_r[1]) && held_r[1].nr == lack_r[1] &&
                    held_r[1].ns == $past(nsn_r[1])))
    else $error("stamped packet numbers wrong");

  a_orig_save: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc && tx_pkt.grp == 3'h2 && stamp_e[1]) |=>
    (orig_r[1] == $past(tx_pkt.ns)))
    else $error("originator number not saved");

  a_retry_limit: assert property (@(posedge core_clk) disable iff (!arst_n)
    (retry_e[2] && try_r[2] <= `RNLA_MAX_TRIES) |=>
    (slot_v_r[4] && try_r[2] == $past(try_r[2]) + 3'h1 && outst_r[2]))
    else $error("retry did not resend");

  a_retry_drop: assert property (@(posedge core_clk) disable iff (!arst_n)
    (retry_e[2] && try_r[2] > `RNLA_MAX_TRIES) |=> (!outst_r[2] && !slot_v_r[4]))
    else $error("packet over try limit not disposed");

  a_retry_nr: assert property (@(posedge core_clk) disable iff (!arst_n)
    retry_e[2] |=> (held_r[2].nr == $past(nr_r[2])))
    else $error("retry kept a stale receive number");

  a_svc_cause: assert property (@(posedge core_clk) disable iff (!arst_n)
    svc_valid |-> ($past(drop_v) && $past(drop_p.dconf) &&
                   svc_tag == $past(drop_p.tag)))
    else $error("service signal without a confirmed drop");

  a_flush_end: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == RNLA_FLUSH && state_nxt == RNLA_IDLE) |->
    (outst_r == 4'h0 && nz == 4'h0))
    else $error("flush ended with packets left");

endmodule // rnla_engine

// ---- verification/rnla_link_model.sv ----
`timescale 1ns/1ps
module rnla_link_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic stall_en,
  output logic out_ready
);
  int seed = 6128;
  int r;
  // link layer drains the output queue, stalling at random when allowed
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_ready <= 1'b0;
    end else begin
      r = $random(seed);
      out_ready <= !stall_en || (r[1:0] != 2'h0);
    end
  end
endmodule // rnla_link_model

// ---- verification/radio_net_layer_arq_tb.sv ----
`timescale 1ns/1ps
module radio_net_layer_arq_tb;
  import rnla_pkg::*;
  logic core_clk, arst_n, tx_valid, tx_ready, out_valid, out_ready, stall_en;
  logic rx_valid, fwd_valid, dup_drop, ack_valid, nr_valid, svc_valid;
  logic reg_wr, reg_rd;
  rnla_pkt_s tx_pkt, out_pkt, e, a, b, c, d, f, m;
  rnla_rx_s rx_pkt, fwd_pkt;
  logic [59:0] out_user, fwd_user;
  logic [2:0] ack_grp, nr_grp;
  rnla_seq_t nr_value;
  logic [15:0] svc_tag;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int fail_count, check_count, seed;
  rnla_seq_t odd_ns [8];
  rnla_seq_t even_ns [8];
  rnla_seq_t nr_of [8];
  rnla_pkt_s exp_out [$];
  logic [15:0] exp_svc [$];
  logic [71:0] exp_rx [$];
  logic [71:0] rx_w;
  logic [3:0] ids [6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h2};
  // grp, ns, direct, forwarded
  logic [11:0] rx_tab [11] = '{{3'h1, 7'h7F, 2'h0}, {3'h1, 7'h05, 2'h1},
    {3'h1, 7'h05, 2'h0}, {3'h1, 7'h05, 2'h3}, {3'h1, 7'h06, 2'h1},
    {3'h1, 7'h07, 2'h1}, {3'h1, 7'h08, 2'h1}, {3'h1, 7'h05, 2'h1},
    {3'h3, 7'h7F, 2'h0}, {3'h2, 7'h7F, 2'h1}, {3'h2, 7'h7F, 2'h1}};

  rnla_engine dut (.core_clk(core_clk), .arst_n(arst_n),
    .tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready),
    .out_valid(out_valid), .out_pkt(out_pkt), .out_user(out_user),
    .out_ready(out_ready), .rx_valid(rx_valid), .rx_pkt(rx_pkt),
    .fwd_valid(fwd_valid), .fwd_pkt(fwd_pkt), .fwd_user(fwd_user),
    .dup_drop(dup_drop), .ack_valid(ack_valid), .ack_grp(ack_grp),
    .nr_valid(nr_valid), .nr_grp(nr_grp), .nr_value(nr_value),
    .svc_valid(svc_valid), .svc_tag(svc_tag), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  rnla_link_model link (.core_clk(core_clk), .arst_n(arst_n),
    .stall_en(stall_en), .out_ready(out_ready));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [59:0] key_of(input logic [59:0] ad);
    case (ad[59:56])
      4'h3, 4'h5: return {ad[59:12], 12'h000};
      4'h1, 4'h4, 4'h6: return {ad[59:8], 8'h00};
      default: return ad;
    endcase
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic send(input logic [2:0] g, input logic dc,
                      input logic [3:0] id, output rnla_pkt_s p);
    int k;
    @(posedge core_clk);
    p = rnla_pkt_s'({$random(seed), $random(seed), $random(seed)});
    p.grp = g;
    p.dconf = dc;
    p.addr[59:56] = id;
    for (k = 0; k < 14; k++) begin
      p.addr[k*4+:4] = 4'(1 + $unsigned($random(seed)) % 9);
    end
    tx_pkt <= p;
    tx_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (tx_ready !== 1'b1 && k < 500);
    if (k >= 500) begin
      fail_count++;
      stop_test();
    end
    tx_valid <= 1'b0;
  endtask

  task automatic expect_pkt(input rnla_pkt_s p);
    e = p;
    if (p.grp[0]) begin
      e.ns = odd_ns[p.grp];
      odd_ns[p.grp]++;
    end else begin
      e.ns = even_ns[p.grp];
      e.nr = nr_of[p.grp];
      even_ns[p.grp]++;
    end
    exp_out.push_back(e);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while ((exp_out.size() + exp_svc.size() + exp_rx.size()) != 0) begin
      @(posedge core_clk);
      k++;
      if (k > 3000) begin
        fail_count++;
        stop_test();
      end
    end
  endtask

  task automatic reg_acc(input logic wr, input logic [3:0] ad,
                         input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
    if (!wr) check(64'(reg_rdata), 64'(v), "reg read");
  endtask

  task automatic pulse(input int kind, input logic [2:0] g,
                       input rnla_seq_t v);
    @(posedge core_clk);
    ack_grp <= g;
    nr_grp <= g;
    nr_value <= v;
    ack_valid <= (kind == 0);
    nr_valid <= (kind == 1);
    @(posedge core_clk);
    ack_valid <= 1'b0;
    nr_valid <= 1'b0;
    if (kind == 1) nr_of[g] = v;
  endtask

  always @(posedge core_clk) begin
    if (arst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_out.size() == 0) begin
        check(64'h1, 64'h0, "unexpected out");
      end else begin
        m = exp_out.pop_front();
        check(64'({out_pkt.grp, out_pkt.ns, out_pkt.dconf, out_pkt.tag}),
              64'({m.grp, m.ns, m.dconf, m.tag}), "out pkt");
        check(64'(out_pkt.addr), 64'(m.addr), "out addr");
        check(64'(out_user), 64'(key_of(m.addr)), "user");
        if (!m.grp[0]) check(64'(out_pkt.nr), 64'(m.nr), "nr");
      end
    end
    if (arst_n === 1'b1 && svc_valid === 1'b1) begin
      if (exp_svc.size() == 0) check(64'h1, 64'h0, "svc");
      else check(64'(svc_tag), 64'(exp_svc.pop_front()), "svc");
    end
    if (arst_n === 1'b1 && (fwd_valid === 1'b1 || dup_drop === 1'b1)) begin
      if (exp_rx.size() == 0) begin
        check(64'h1, 64'h0, "rx");
      end else begin
        rx_w = exp_rx.pop_front();
        check(64'({fwd_valid, fwd_user}), 64'(rx_w[60:0]),
              "rx");
        check(64'({fwd_pkt.grp, fwd_pkt.ns, fwd_pkt.direct, dup_drop}),
              64'({rx_w[71:61], !rx_w[60]}), "rx pkt");
      end
    end
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    seed = 6128;
    {arst_n, tx_valid, rx_valid, ack_valid, nr_valid, reg_wr, reg_rd} = '0;
    {tx_pkt, rx_pkt, ack_grp, nr_grp, nr_value, reg_addr, reg_wdata} = '0;
    stall_en = 1'b1;
    odd_ns = '{default: 7'h00};
    even_ns = '{default: 7'h00};
    nr_of = '{default: 7'h00};
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    reg_acc(1'b0, 4'h0, 32'h00000400);
    reg_acc(1'b0, 4'h4, 32'h00100000);
    reg_acc(1'b0, 4'h8, 32'h00000000);
    reg_acc(1'b1, 4'hC, 32'h0000FFFF);
    reg_acc(1'b0, 4'hC, 32'h00000000);
    for (int i = 0; i < 264; i++) begin
      send(i < 256 ? 3'(1 + 2 * (i % 2)) : 3'(1 + 2 * (i % 4)),
           1'($random(seed)), ids[i % 6], a);
      expect_pkt(a);
    end
    wait_idle();
    for (int i = 0; i < 11; i++) begin
      @(posedge core_clk);
      rx_pkt.grp <= rx_tab[i][11:9];
      rx_pkt.ns <= rx_tab[i][8:2];
      rx_pkt.direct <= rx_tab[i][1];
      rx_pkt.addr <= {ids[i % 6], 56'h12345678912345};
      rx_valid <= 1'b1;
      exp_rx.push_back({rx_tab[i][11:0],
                        key_of({ids[i % 6], 56'h12345678912345})});
      @(posedge core_clk);
      rx_valid <= 1'b0;
    end
    wait_idle();
    pulse(1, 3'h2, 7'h05);
    send(3'h2, 1'b0, 4'h1, a);
    expect_pkt(a);
    send(3'h2, 1'b0, 4'h3, b);
    wait_idle();
    reg_acc(1'b0, 4'h8, 32'h00000022);
    expect_pkt(b);
    pulse(0, 3'h2, 7'h00);
    wait_idle();
    reg_acc(1'b0, 4'h8, 32'h00000002);
    pulse(0, 3'h2, 7'h00);
    reg_acc(1'b0, 4'h8, 32'h00000000);
    stall_en <= 1'b0;
    reg_acc(1'b1, 4'h0, 32'h00000010);
    send(3'h4, 1'b1, 4'h4, c);
    expect_pkt(c);
    wait_idle();
    pulse(1, 3'h4, 7'h09);
    e.nr = 7'h09;
    repeat (6) exp_out.push_back(e);
    exp_svc.push_back(c.tag);
    wait_idle();
    reg_acc(1'b1, 4'h0, 32'h00000400);
    stall_en <= 1'b1;
    reg_acc(1'b1, 4'h4, 32'h000000C8);
    pulse(0, 3'h0, 7'h00);
    send(3'h6, 1'b1, 4'h5, d);
    expect_pkt(d);
    send(3'h6, 1'b0, 4'h6, f);
    exp_svc.push_back(d.tag);
    wait_idle();
    repeat (8) @(posedge core_clk);
    reg_acc(1'b0, 4'h8, 32'h00000000);
    stop_test();
  end
endmodule // radio_net_layer_arq_tb
